// ### mac_rx_length_and_error_counters.sv
// Summary of operation
// RULE1 - the 12-bit limit field is read/write, low in its word, reset zero.
// RULE2 - reserved register bits always read as zero.
// RULE3 - the checked length runs from destination address to checksum end.
// RULE4 - bytes up to the payload end go out, the checksum bytes do not.
// RULE5 - every byte of a frame beyond the limit is thrown away.
// RULE6 - up to 0x5ee means 1518 bytes, up to 0x7ff itself, else 2048 bytes.
// RULE7 - software leaves the limit alone while reception is enabled.
// RULE8 - bit 0 of the read-only link register shows the pin, the rest read 0.
// RULE9 - a 32-bit count, reset zero, of frames abandoned after all attempts.
// RULE10 - each frame failing its 16th attempt adds one to the retry count.
// RULE11 - the retry-over count holds once it reaches its top value.
// RULE12 - a 32-bit count, reset zero, of late collisions after transmit start.
// RULE13 - the late collision count holds once it reaches its top value.
// RULE14 - a write of any value to a counter clears it, the data is ignored.
// RULE15 - a clearing write beats a counting event in the same cycle.
// RULE16 - the link pin sets the link-change flag, its enable resets to zero.
`timescale 1ns/100ps
`default_nettype none
module mac_rx_length_and_error_counters (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic awvalid,
   output logic awready,
   input wire logic [mac_rx_limit_pkg::ADDR_W-1:0] awaddr,
   input wire logic wvalid,
   output logic wready,
   input wire logic [mac_rx_limit_pkg::DATA_W-1:0] wdata,
   input wire logic [3:0] wstrb,
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   input wire logic arvalid,
   output logic arready,
   input wire logic [mac_rx_limit_pkg::ADDR_W-1:0] araddr,
   output logic rvalid,
   input wire logic rready,
   output logic [mac_rx_limit_pkg::DATA_W-1:0] rdata,
   output logic [1:0] rresp,
   input wire logic rx_valid,
   input wire logic [7:0] rx_data,
   input wire logic rx_last,
   output logic fwd_valid,
   output logic [7:0] fwd_data,
   output logic fwd_end,
   output logic fwd_too_long,
   input wire logic link_status_pin,
   input wire logic retry_over_event,
   input wire logic late_collision_event,
   output logic irq
);
   import mac_rx_limit_pkg::*;

   // ***************************************************
   // helpers
   // ***************************************************
   // word address match
   function automatic logic hit(input logic [ADDR_W-1:0] a,
                                input logic [ADDR_W-1:0] off);
      hit = (a[ADDR_W-1:2] == off[ADDR_W-1:2]);
   endfunction : hit

   // saturating counter step, clear first
   function automatic logic [DATA_W-1:0] step(input logic [DATA_W-1:0] v,
                                              input logic ev,
                                              input logic clr);
      if (clr)
         step = COUNT_RESET;
      else if (ev && v != COUNT_MAX)
         step = v + 32'h1;
      else
         step = v;
   endfunction : step

   // ***************************************************
   // state
   // ***************************************************
   logic [LIMIT_W-1:0] receive_length_limit;
   logic link_level_view;
   logic [DATA_W-1:0] retry_over_value;
   logic [DATA_W-1:0] late_collision_value;
   logic [IRQ_W-1:0] irq_status;
   logic [IRQ_W-1:0] irq_mask;
   logic aw_held, w_held;
   logic [ADDR_W-1:0] aw_addr_q;
   logic [DATA_W-1:0] w_data_q;
   logic [3:0] w_strb_q;
   logic [FCS_BYTES-1:0][7:0] pipe;
   logic [2:0] pipe_count;
   logic [POS_W-1:0] in_pos, out_pos;

   // ***************************************************
   // bus decode
   // ***************************************************
   wire aw_take = awvalid & awready;
   wire w_take = wvalid & wready;
   wire do_write = aw_held & w_held & ~bvalid;
   wire ar_take = arvalid & arready;
   wire wr_limit = do_write & hit(aw_addr_q, OFF_RX_LIMIT);
   wire wr_phy = do_write & hit(aw_addr_q, OFF_PHY_STATUS);
   wire clear_retry = do_write & hit(aw_addr_q, OFF_RETRY_OVER);
   wire clear_late = do_write & hit(aw_addr_q, OFF_LATE_COLL);
   wire wr_status = do_write & hit(aw_addr_q, OFF_IRQ_STATUS);
   wire wr_mask = do_write & hit(aw_addr_q, OFF_IRQ_MASK);
   wire wr_mapped = wr_limit | wr_phy | clear_retry | clear_late
                    | wr_status | wr_mask;
   wire rd_limit = hit(araddr, OFF_RX_LIMIT);
   wire rd_phy = hit(araddr, OFF_PHY_STATUS);
   wire rd_retry = hit(araddr, OFF_RETRY_OVER);
   wire rd_late = hit(araddr, OFF_LATE_COLL);
   wire rd_status = hit(araddr, OFF_IRQ_STATUS);
   wire rd_mask = hit(araddr, OFF_IRQ_MASK);
   wire rd_mapped = rd_limit | rd_phy | rd_retry | rd_late
                    | rd_status | rd_mask;
   wire next_aw_held = (aw_held & ~do_write) | aw_take;
   wire next_w_held = (w_held & ~do_write) | w_take;
   wire next_rvalid = (rvalid & ~rready) | ar_take;

   // read mux, reserved bits zero
   wire [DATA_W-1:0] read_word =
      rd_limit ? {20'h0, receive_length_limit} :           // see RULE2
      rd_phy ? {31'h0, link_level_view} :                  // see RULE8
      rd_retry ? retry_over_value :
      rd_late ? late_collision_value :
      rd_status ? {28'h0, irq_status} :
      rd_mask ? {28'h0, irq_mask} : 32'h0;

   // byte-lane merge for the limit field
   wire [LIMIT_W-1:0] next_limit =
      {wstrb_hi(w_strb_q[1], w_data_q[11:8], receive_length_limit[11:8]),
       w_strb_q[0] ? w_data_q[7:0] : receive_length_limit[7:0]};

   function automatic logic [3:0] wstrb_hi(input logic s,
                                           input logic [3:0] n,
                                           input logic [3:0] o);
      wstrb_hi = s ? n : o;
   endfunction : wstrb_hi

   // ***************************************************
   // receive length limit
   // ***************************************************
   // effective limit in bytes
   wire [LIMIT_W-1:0] eff_limit =
      (receive_length_limit <= LIMIT_STD_TOP) ? LIMIT_STD_BYTES :  // see RULE6
      (receive_length_limit <= LIMIT_OWN_TOP) ? receive_length_limit :
      LIMIT_MAX_BYTES;
   wire pipe_full = (pipe_count == PIPE_FULL);
   wire [POS_W-1:0] emit_pos = (out_pos == POS_MAX) ? out_pos
                               : out_pos + 16'h1;
   wire [POS_W-1:0] in_pos_inc = (in_pos == POS_MAX) ? in_pos
                                 : in_pos + 16'h1;
   // oldest byte leaves only once four newer ones follow it
   wire emit = rx_valid & pipe_full;                        // see RULE4
   wire emit_ok = emit & (emit_pos <= {4'h0, eff_limit});  // see RULE5
   wire frame_long = rx_valid & rx_last
                     & (in_pos_inc > {4'h0, eff_limit});   // see RULE3

   // ***************************************************
   // events and interrupt
   // ***************************************************
   wire link_change = link_status_pin ^ link_level_view;
   wire [IRQ_W-1:0] events;
   assign events[IRQ_LINK_CHANGE] = link_change;          // see RULE16
   assign events[IRQ_RETRY_OVER] = retry_over_event;
   assign events[IRQ_LATE_COLL] = late_collision_event;
   assign events[IRQ_TOO_LONG] = frame_long;
   wire read_clears = ar_take & rd_status;
   // set wins over clear-on-read
   wire [IRQ_W-1:0] next_status =
      (irq_status & ~{IRQ_W{read_clears}}) | events;
   wire [IRQ_W-1:0] next_mask = wr_mask ? w_data_q[IRQ_W-1:0] : irq_mask;

   // ***************************************************
   // write channel
   // ***************************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         awready <= 1'b0;
         wready <= 1'b0;
         aw_addr_q <= '0;
         w_data_q <= '0;
         w_strb_q <= 4'h0;
      end else begin
         aw_held <= next_aw_held;
         w_held <= next_w_held;
         awready <= ~next_aw_held;
         wready <= ~next_w_held;
         if (aw_take) aw_addr_q <= awaddr;
         if (w_take) w_data_q <= wdata;
         if (w_take) w_strb_q <= wstrb;
      end
   end

   // write response after both halves are in
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid <= 1'b0;
         bresp <= RESP_OKAY;
      end else if (do_write) begin
         bvalid <= 1'b1;
         bresp <= wr_mapped ? RESP_OKAY : RESP_DECERR;
      end else if (bready) begin
         bvalid <= 1'b0;
      end
   end

   // ***************************************************
   // read channel
   // ***************************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid <= 1'b0;
         arready <= 1'b0;
         rdata <= '0;
         rresp <= RESP_OKAY;
      end else begin
         rvalid <= next_rvalid;
         arready <= ~next_rvalid;
         if (ar_take) rdata <= read_word;
         if (ar_take) rresp <= rd_mapped ? RESP_OKAY : RESP_DECERR;
      end
   end

   // ***************************************************
   // registers and counters
   // ***************************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         receive_length_limit <= LIMIT_RESET;              // see RULE1
         link_level_view <= 1'b0;
         retry_over_value <= COUNT_RESET;                  // see RULE9
         late_collision_value <= COUNT_RESET;              // see RULE12
         irq_status <= IRQ_RESET;
         irq_mask <= IRQ_RESET;                            // see RULE16
         irq <= 1'b0;
      end else begin
         if (wr_limit) receive_length_limit <= next_limit; // see RULE1
         link_level_view <= link_status_pin;               // see RULE8
         // clear beats count, count sticks at top
         retry_over_value <= step(retry_over_value, retry_over_event,
                                  clear_retry);   // see RULE10 RULE11 RULE14
         late_collision_value <= step(late_collision_value,
                                      late_collision_event,
                                      clear_late); // see RULE13 RULE15
         irq_status <= next_status;
         irq_mask <= next_mask;
         irq <= |(next_status & next_mask);                // see RULE16
      end
   end

   // ***************************************************
   // receive byte path
   // ***************************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pipe <= '0;
         pipe_count <= 3'h0;
         in_pos <= '0;
         out_pos <= '0;
         fwd_valid <= 1'b0;
         fwd_data <= 8'h00;
         fwd_end <= 1'b0;
         fwd_too_long <= 1'b0;
      end else begin
         fwd_valid <= emit_ok;
         fwd_end <= rx_valid & rx_last;
         if (emit) fwd_data <= pipe[FCS_BYTES-1];
         if (rx_valid && rx_last) fwd_too_long <= frame_long;
         if (rx_valid) begin
            pipe <= {pipe[FCS_BYTES-2:0], rx_data};
            // last four bytes at frame end are dropped here
            if (rx_last) begin
               pipe_count <= 3'h0;                         // see RULE4
               in_pos <= '0;
               out_pos <= '0;
            end else begin
               if (!pipe_full) pipe_count <= pipe_count + 3'h1;
               in_pos <= in_pos_inc;
               if (emit) out_pos <= emit_pos;
            end
         end
      end
   end

   // ***************************************************
   // checks
   // ***************************************************
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   chk_limit_write: assert property ( // see RULE1
      (wr_limit && w_strb_q[1:0] == 2'h3) |=>
         receive_length_limit == $past(w_data_q[11:0]))
      else $error("limit field did not take the write");
   chk_reserved_zero: assert property ( // see RULE2
      (ar_take && rd_limit) |=> rdata[31:12] == 20'h0)
      else $error("reserved limit bits read nonzero");
   chk_eff_limit: assert property ( // see RULE6
      (receive_length_limit <= 12'h5ee && eff_limit == 12'h5ee) ||
      (receive_length_limit >= 12'h800 && eff_limit == 12'h800) ||
      (receive_length_limit > 12'h5ee && receive_length_limit < 12'h800
       && eff_limit == receive_length_limit))
      else $error("effective limit mapping wrong");
   chk_fcs_held: assert property ( // see RULE4
      fwd_valid |-> $past(pipe_count) == PIPE_FULL && $past(rx_valid))
      else $error("byte forwarded before four newer bytes");
   chk_no_excess: assert property ( // see RULE5
      emit && (emit_pos > {4'h0, eff_limit}) |=> !fwd_valid)
      else $error("byte beyond limit forwarded");
   chk_too_long_flag: assert property ( // see RULE3
      (rx_valid && rx_last && in_pos >= {4'h0, eff_limit}) |=>
         fwd_too_long && fwd_end)
      else $error("overlong frame not flagged");
   chk_link_view: assert property ( // see RULE8
      (ar_take && rd_phy) |=> rdata == {31'h0, $past(link_level_view)})
      else $error("link status read wrong");
   chk_retry_step: assert property ( // see RULE10
      (retry_over_event && !clear_retry && retry_over_value != 32'hffffffff)
      |=> retry_over_value == $past(retry_over_value) + 32'h1)
      else $error("retry-over count did not step by one");
   chk_retry_hold: assert property ( // see RULE11
      (retry_over_value == 32'hffffffff && !clear_retry) |=>
         retry_over_value == 32'hffffffff)
      else $error("retry-over count wrapped");
   chk_late_hold: assert property ( // see RULE13
      (late_collision_value == 32'hffffffff && !clear_late) |=>
         late_collision_value == 32'hffffffff)
      else $error("late collision count wrapped");
   chk_clear_wins: assert property ( // see RULE15
      (clear_late || clear_retry) |=>
         (!$past(clear_late) || late_collision_value == 32'h0) &&
         (!$past(clear_retry) || retry_over_value == 32'h0))
      else $error("counter not zero after clearing write");
   chk_link_flag: assert property ( // see RULE16
      link_change |=> irq_status[0] ##0 (irq == irq_mask[0] || irq))
      else $error("link change not flagged");
   chk_irq_gate: assert property ( // see RULE16
      irq == |(irq_status & irq_mask))
      else $error("interrupt output disagrees with status and mask");

   cov_too_long: cover property (fwd_end && fwd_too_long);
   cov_retry_clear: cover property (clear_retry && retry_over_event);
   cov_link_irq: cover property (link_change ##1 irq);
   cov_status_read: cover property (read_clears && |irq_status);
endmodule : mac_rx_length_and_error_counters
`default_nettype wire

// ### mac_rx_limit_pkg.sv
`default_nettype none
package mac_rx_limit_pkg;
   // ***************************************************
   // bus geometry
   // ***************************************************
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_DECERR = 2'h3;

   // ***************************************************
   // register byte offsets
   // ***************************************************
   localparam logic [ADDR_W-1:0] OFF_RX_LIMIT = 8'h00;
   localparam logic [ADDR_W-1:0] OFF_PHY_STATUS = 8'h04;
   localparam logic [ADDR_W-1:0] OFF_RETRY_OVER = 8'h08;
   localparam logic [ADDR_W-1:0] OFF_LATE_COLL = 8'h0c;
   localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS = 8'h10;
   localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 8'h14;

   // ***************************************************
   // fields and reset values
   // ***************************************************
   localparam int LIMIT_W = 12;
   localparam logic [LIMIT_W-1:0] LIMIT_RESET = 12'h000;
   localparam logic [LIMIT_W-1:0] LIMIT_STD_TOP = 12'h5ee;
   localparam logic [LIMIT_W-1:0] LIMIT_STD_BYTES = 12'h5ee;
   localparam logic [LIMIT_W-1:0] LIMIT_OWN_TOP = 12'h7ff;
   localparam logic [LIMIT_W-1:0] LIMIT_MAX_BYTES = 12'h800;
   localparam int LINK_BIT = 0;
   localparam logic [DATA_W-1:0] COUNT_RESET = 32'h0000_0000;
   localparam logic [DATA_W-1:0] COUNT_MAX = 32'hffff_ffff;

   // interrupt status and mask share this layout
   localparam int IRQ_W = 4;
   localparam int IRQ_LINK_CHANGE = 0;
   localparam int IRQ_RETRY_OVER = 1;
   localparam int IRQ_LATE_COLL = 2;
   localparam int IRQ_TOO_LONG = 3;
   localparam logic [IRQ_W-1:0] IRQ_RESET = 4'h0;

   // ***************************************************
   // receive path
   // ***************************************************
   localparam int FCS_BYTES = 4;
   localparam int POS_W = 16;
   localparam logic [2:0] PIPE_FULL = 3'h4;
   localparam logic [POS_W-1:0] POS_MAX = 16'hffff;
endpackage : mac_rx_limit_pkg
`default_nettype wire

// ### phy_rx_model.sv
`timescale 1ns/100ps
`default_nettype none
// ***************************************************
// receive side of the phy: byte stream and link level
// ***************************************************
module phy_rx_model (
   input wire logic aclk,
   input wire logic start,
   input wire logic [15:0] len,
   input wire logic slow,
   input wire logic link_set,
   output logic rx_valid,
   output logic [7:0] rx_data,
   output logic rx_last,
   output logic busy,
   output logic link_status_pin
);
   logic [15:0] pos;
   logic gap;
   initial begin
      rx_valid = 1'b0;
      rx_data = 8'h5a;
      rx_last = 1'b0;
      busy = 1'b0;
      link_status_pin = 1'b0;
      pos = 16'h0001;
      gap = 1'b0;
   end
   // one byte per cycle, or every other cycle when slow
   always @(posedge aclk) begin
      link_status_pin <= link_set;
      gap <= ~gap;
      if (start && !busy) begin
         busy <= 1'b1;
         pos <= 16'h0001;
      end
      if (busy && !(slow && gap)) begin
         rx_valid <= 1'b1;
         rx_data <= pos[7:0]; // byte n carries n, checksum bytes last
         rx_last <= (pos == len);
         pos <= pos + 16'h0001;
         if (pos == len) begin
            busy <= 1'b0;
         end
      end else begin
         rx_valid <= 1'b0;
         rx_last <= 1'b0;
         rx_data <= ~rx_data; // idle line toggles, showing the last byte inverted every other cycle
      end
   end
endmodule : phy_rx_model
`default_nettype wire

// ### tb_mac_rx_length_and_error_counters.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin error_cnt++; \
   $display("mismatch %s expected %h seen %h", nm, e, g); end end
module tb_mac_rx_length_and_error_counters;
   import mac_rx_limit_pkg::*;
   logic aclk = 1'b0, aresetn = 1'b0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0, start = 1'b0, slow = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, seed = 32'h17, rd;
   logic [3:0] wstrb = 4'hf;
   logic retry_over_event = 1'b0, late_collision_event = 1'b0;
   logic link_set = 1'b0, too_long_seen, end_seen;
   logic [15:0] len_q = 16'h0;
   logic awready, wready, bvalid, arready, rvalid, rx_valid, rx_last;
   logic fwd_valid, fwd_end, fwd_too_long, link_status_pin, irq, busy;
   logic [1:0] bresp, rresp, rs;
   logic [31:0] rdata;
   logic [7:0] rx_data, fwd_data;
   int error_cnt = 0, checked = 0, fwd_cnt, n_ro, n_lc, fwd_exp;
   logic [11:0] lims [8] = '{12'h000, 12'h000, 12'h5ee, 12'h5ef, 12'h7ff,
      12'h800, 12'hfff, 12'h100};
   int lens [8] = '{1518, 1522, 1530, 1530, 2060, 2100, 2060, 3};
   always #50 aclk = ~aclk;
   mac_rx_length_and_error_counters mac_rx_length_and_error_counters_inst (
      .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
      .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata),
      .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp),
      .arvalid(arvalid), .arready(arready), .araddr(araddr),
      .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
      .rx_valid(rx_valid), .rx_data(rx_data), .rx_last(rx_last),
      .fwd_valid(fwd_valid), .fwd_data(fwd_data), .fwd_end(fwd_end),
      .fwd_too_long(fwd_too_long), .link_status_pin(link_status_pin),
      .retry_over_event(retry_over_event),
      .late_collision_event(late_collision_event), .irq(irq));
   phy_rx_model phy_rx_model_inst (
      .aclk(aclk), .start(start), .len(len_q), .slow(slow),
      .link_set(link_set), .rx_valid(rx_valid), .rx_data(rx_data),
      .rx_last(rx_last), .busy(busy), .link_status_pin(link_status_pin));
   // ***************************************************
   // helpers: random source, expectations, verdict
   // ***************************************************
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : xs
   function automatic int eff_limit(input logic [11:0] v);
      if (v <= LIMIT_STD_TOP) return int'(LIMIT_STD_BYTES);
      if (v <= LIMIT_OWN_TOP) return int'(v);
      return int'(LIMIT_MAX_BYTES);
   endfunction : eff_limit
   function automatic int exp_fwd(input logic [11:0] v, input int n);
      int body;
      body = (n > FCS_BYTES) ? n - FCS_BYTES : 0;
      return (body < eff_limit(v)) ? body : eff_limit(v);
   endfunction : exp_fwd
   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : report_and_stop
   // ***************************************************
   // register bus master; sel 1/2 fires an event with the write
   // ***************************************************
   task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
      input int sel, output logic [1:0] r);
      int n;
      logic ga, gw, gb, fired, hit;
      n = 0; ga = 0; gw = 0; gb = 0; fired = 0; hit = 0; r = 2'h0;
      @(posedge aclk);
      awvalid <= 1'b1; awaddr <= a; wvalid <= 1'b1; wdata <= d;
      bready <= 1'b1;
      while (!gb && n < 200) begin
         @(posedge aclk);
         n++;
         if (hit) begin
            retry_over_event <= 1'b0; late_collision_event <= 1'b0; hit = 0;
         end
         if (!ga && awready === 1'b1) begin ga = 1; awvalid <= 1'b0; end
         if (!gw && wready === 1'b1) begin gw = 1; wvalid <= 1'b0; end
         if (ga && gw && !fired) begin
            fired = 1; hit = 1;
            if (sel == 1) retry_over_event <= 1'b1;
            if (sel == 2) late_collision_event <= 1'b1;
         end else if (bvalid === 1'b1) begin
            gb = 1; r = bresp; bready <= 1'b0;
         end
      end
      if (!gb) begin error_cnt++; report_and_stop(); end
   endtask : axi_write
   task automatic axi_read(input logic [7:0] a, output logic [31:0] d,
      output logic [1:0] r);
      int n;
      logic ga, gr;
      n = 0; ga = 0; gr = 0; d = 32'h0; r = 2'h0;
      @(posedge aclk);
      arvalid <= 1'b1; araddr <= a; rready <= 1'b1;
      while (!gr && n < 200) begin
         @(posedge aclk);
         n++;
         if (!ga && arready === 1'b1) begin ga = 1; arvalid <= 1'b0; end
         else if (ga && rvalid === 1'b1) begin
            gr = 1; d = rdata; r = rresp; rready <= 1'b0;
         end
      end
      if (!gr) begin error_cnt++; report_and_stop(); end
   endtask : axi_read
   task automatic rd_chk(input string nm, input logic [7:0] a,
      input logic [31:0] e, input logic [1:0] er);
      logic [31:0] d;
      logic [1:0] r;
      axi_read(a, d, r);
      `CHK(nm, e, d)
      `CHK("rresp", er, r)
   endtask : rd_chk
   task automatic wait_cyc(input int n);
      repeat (n) @(posedge aclk);
   endtask : wait_cyc
   // ***************************************************
   // forwarded byte monitor
   // ***************************************************
   always @(posedge aclk) begin
      if (fwd_valid === 1'b1) begin
         `CHK("fwd_data", 8'(fwd_cnt + 1), fwd_data)
         fwd_cnt++;
      end
      if (fwd_end === 1'b1) begin
         end_seen = 1'b1; too_long_seen = fwd_too_long;
      end
   end
   // ***************************************************
   // main sequence
   // ***************************************************
   initial begin
      wait_cyc(2);
      aresetn <= 1'b1;
      rd_chk("limit_rst", OFF_RX_LIMIT, 32'h0, RESP_OKAY);
      rd_chk("link_rst", OFF_PHY_STATUS, 32'h0, RESP_OKAY);
      rd_chk("retry_rst", OFF_RETRY_OVER, 32'h0, RESP_OKAY);
      rd_chk("late_rst", OFF_LATE_COLL, 32'h0, RESP_OKAY);
      rd_chk("mask_rst", OFF_IRQ_MASK, 32'h0, RESP_OKAY);
      rd_chk("unmapped", 8'h20, 32'h0, RESP_DECERR);
      axi_write(8'h20, xs(), 0, rs);
      `CHK("wr_unmapped", RESP_DECERR, rs)
      // limit field keeps 12 bits, upper bits read zero
      rd = xs();
      axi_write(OFF_RX_LIMIT, rd, 0, rs);
      rd[31:12] = 20'h0;
      rd_chk("limit_rw", OFF_RX_LIMIT, rd, RESP_OKAY);
      // a write with only lane 0 enabled keeps the upper nibble
      wstrb <= 4'h1;
      axi_write(OFF_RX_LIMIT, 32'h0000_0fff, 0, rs);
      wstrb <= 4'hf;
      rd[7:0] = 8'hff;
      rd_chk("limit_strb", OFF_RX_LIMIT, rd, RESP_OKAY);
      // link level, read-only view, change interrupt gated by the enable
      link_set <= 1'b1;
      wait_cyc(4);
      `CHK("irq_masked", 1'b0, irq)
      axi_write(OFF_PHY_STATUS, 32'hffff_fffe, 0, rs);
      rd_chk("link_hi", OFF_PHY_STATUS, 32'h1, RESP_OKAY);
      axi_read(OFF_IRQ_STATUS, rd, rs);
      `CHK("link_flag", 1'b1, rd[IRQ_LINK_CHANGE])
      axi_write(OFF_IRQ_MASK, 32'h1, 0, rs);
      link_set <= 1'b0;
      wait_cyc(4);
      `CHK("irq_on", 1'b1, irq)
      axi_read(OFF_IRQ_STATUS, rd, rs);
      wait_cyc(2);
      `CHK("irq_off", 1'b0, irq)
      // random event pulses on both counters
      n_ro = 0; n_lc = 0;
      repeat (64) begin
         rd = xs();
         @(posedge aclk);
         retry_over_event <= rd[0]; late_collision_event <= rd[1];
         n_ro += rd[0]; n_lc += rd[1];
         @(posedge aclk);
         retry_over_event <= 1'b0; late_collision_event <= 1'b0;
      end
      wait_cyc(2);
      rd_chk("retry_cnt", OFF_RETRY_OVER, 32'(n_ro), RESP_OKAY);
      rd_chk("late_cnt", OFF_LATE_COLL, 32'(n_lc), RESP_OKAY);
      axi_write(OFF_RETRY_OVER, xs(), 1, rs);
      axi_write(OFF_LATE_COLL, xs(), 0, rs);
      rd_chk("retry_clr", OFF_RETRY_OVER, 32'h0, RESP_OKAY);
      rd_chk("late_clr", OFF_LATE_COLL, 32'h0, RESP_OKAY);
      @(posedge aclk) retry_over_event <= 1'b1;
      @(posedge aclk) retry_over_event <= 1'b0;
      wait_cyc(2);
      rd_chk("retry_one", OFF_RETRY_OVER, 32'h1, RESP_OKAY);
      // frames against limits, limit changed only between frames
      for (int i = 0; i < 8; i++) begin
         axi_write(OFF_RX_LIMIT, {20'h0, lims[i]}, 0, rs);
         fwd_cnt = 0; end_seen = 1'b0;
         rd = xs();
         @(posedge aclk);
         start <= 1'b1;
         len_q <= 16'(lens[i]);
         slow <= rd[0];
         @(posedge aclk) start <= 1'b0;
         for (int n = 0; n < 5000 && end_seen !== 1'b1; n++) wait_cyc(1);
         if (end_seen !== 1'b1) begin error_cnt++; report_and_stop(); end
         fwd_exp = exp_fwd(lims[i], lens[i]);
         `CHK("fwd_count", fwd_exp, fwd_cnt)
         fwd_exp = int'(lens[i] > eff_limit(lims[i]));
         `CHK("too_long", 1'(fwd_exp), too_long_seen)
      end
      report_and_stop();
   end
endmodule : tb_mac_rx_length_and_error_counters
`default_nettype wire
